// file: adcct_regs.svh
`ifndef ADCCT_REGS_SVH
`define ADCCT_REGS_SVH

// basic clock divider, cpu cycles per basic clock period minus one
`define ADCCT_DIV_M1_SEL0 4'h3
`define ADCCT_DIV_M1_SEL1 4'h1
`define ADCCT_DIV_M1_SEL2 4'hf
`define ADCCT_DIV_M1_SEL3 4'h7

// sample phase, basic clock periods minus one
`define ADCCT_SMP_M1_SEL0 6'h07
`define ADCCT_SMP_M1_SEL1 6'h0f
`define ADCCT_SMP_M1_SEL2 6'h1f
`define ADCCT_SMP_M1_SEL3 6'h3f

// bit determination, basic clock periods minus one (40 periods)
`define ADCCT_CONV_BC_M1 6'h27
// result load, cpu cycles minus one (2 cycles)
`define ADCCT_LOAD_CPU_M1 1'h1
// reset calibration, basic clock periods
`define ADCCT_CAL_BC 3328

`define ADCCT_RESULT_ZERO 10'h000
`define ADCCT_RESULT_FULL 10'h3ff

`endif

// file: adcct_pkg.sv
package adcct_pkg;

  typedef enum logic [3:0] {
    ADCCT_IDLE    = 4'b0001,
    ADCCT_SAMPLE  = 4'b0010,
    ADCCT_CONVERT = 4'b0100,
    ADCCT_LOAD    = 4'b1000
  } adcct_state_t;

  typedef struct packed {
    logic [1:0] clk_div_sel;
    logic [1:0] smp_len_sel;
  } adcct_cfg_t;

  typedef struct packed {
    logic       below;
    logic       above;
    logic [9:0] code;
  } adcct_ain_t;

endpackage : adcct_pkg

// file: adcct_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcct_regs.svh"

// Notes on behaviour
// - basic clock is cpu clock divided by 4, 2, 16 or 8 per select code
// - sample phase lasts 8, 16, 32 or 64 basic clock periods per select code
// - conversion takes exactly sample time plus 40 basic periods plus 2 cpu cycles
// - after reset a calibration runs for 3328 basic clock periods
// - conversions are taken during calibration and extend it by their length
// - input below ground gives all zeros, above reference all ones
// - input is captured only in the sample phase, later changes are ignored
module adcct_top #(
  parameter int CAL_BC_PERIODS = `ADCCT_CAL_BC
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                clk_en,
  input  wire logic [1:0]          conv_clock_divider_sel,
  input  wire logic [1:0]          sample_length_sel,
  input  wire logic                conv_start,
  input  wire adcct_pkg::adcct_ain_t ain_pin,
  output logic [9:0]               result_reg,
  output logic                     conv_done_reg,
  output logic                     busy_reg,
  output logic                     sample_phase_reg,
  output logic                     cal_active_reg
);

  // refused at elaboration above 4095, though the 12-bit counter could count 4096
  if (CAL_BC_PERIODS < 1 || CAL_BC_PERIODS > 4095) begin : g_bad_cal
    $error("CAL_BC_PERIODS must be 1 to 4095");
  end

  localparam logic [11:0] CAL_LAST = 12'(CAL_BC_PERIODS - 1);

  function automatic logic [3:0] div_m1(input logic [1:0] sel);
    case (sel)
      2'h0:    div_m1 = `ADCCT_DIV_M1_SEL0;
      2'h1:    div_m1 = `ADCCT_DIV_M1_SEL1;
      2'h2:    div_m1 = `ADCCT_DIV_M1_SEL2;
      default: div_m1 = `ADCCT_DIV_M1_SEL3;
    endcase
  endfunction : div_m1

  function automatic logic [5:0] smp_m1(input logic [1:0] sel);
    case (sel)
      2'h0:    smp_m1 = `ADCCT_SMP_M1_SEL0;
      2'h1:    smp_m1 = `ADCCT_SMP_M1_SEL1;
      2'h2:    smp_m1 = `ADCCT_SMP_M1_SEL2;
      default: smp_m1 = `ADCCT_SMP_M1_SEL3;
    endcase
  endfunction : smp_m1

  // pin synchroniser; the code is assumed to settle before it is used
  adcct_pkg::adcct_ain_t ain_meta_reg;
  adcct_pkg::adcct_ain_t ain_sync_reg;
  adcct_pkg::adcct_ain_t ain_meta_next;
  adcct_pkg::adcct_ain_t ain_sync_next;

  always_comb begin
    ain_meta_next = ain_meta_reg;
    ain_sync_next = ain_sync_reg;
    if (clk_en) begin
      ain_meta_next = ain_pin;
      ain_sync_next = ain_meta_reg;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ain_meta_reg <= '0;
      ain_sync_reg <= '0;
    end else begin
      ain_meta_reg <= ain_meta_next;
      ain_sync_reg <= ain_sync_next;
    end
  end

  // sequencer
  adcct_pkg::adcct_state_t state_reg;
  adcct_pkg::adcct_state_t state_next;
  adcct_pkg::adcct_cfg_t   cfg_reg;
  adcct_pkg::adcct_cfg_t   cfg_next;
  adcct_pkg::adcct_ain_t   hold_reg;
  adcct_pkg::adcct_ain_t   hold_next;
  logic [3:0]              div_cnt_reg;
  logic [3:0]              div_cnt_next;
  logic [5:0]              bc_cnt_reg;
  logic [5:0]              bc_cnt_next;
  logic                    load_cnt_reg;
  logic                    load_cnt_next;
  logic [11:0]             cal_cnt_reg;
  logic [11:0]             cal_cnt_next;
  logic                    cal_active_next;
  logic [9:0]              result_next;
  logic                    conv_done_next;
  logic                    busy_next;
  logic                    sample_phase_next;
  logic                    bc_tick;
  logic [1:0]              div_sel;

  always_comb begin
    state_next        = state_reg;
    cfg_next          = cfg_reg;
    hold_next         = hold_reg;
    div_cnt_next      = div_cnt_reg;
    bc_cnt_next       = bc_cnt_reg;
    load_cnt_next     = load_cnt_reg;
    cal_cnt_next      = cal_cnt_reg;
    cal_active_next   = cal_active_reg;
    result_next       = result_reg;
    conv_done_next    = 1'b0;
    // idle uses live select for calibration, a conversion its latched copy
    // a live select change while idle may stretch one basic period
    div_sel = (state_reg == adcct_pkg::ADCCT_IDLE) ? conv_clock_divider_sel
                                                   : cfg_reg.clk_div_sel;
    bc_tick = (div_cnt_reg == div_m1(div_sel));
    div_cnt_next = bc_tick ? 4'h0 : div_cnt_reg + 4'h1;
    case (state_reg)
      adcct_pkg::ADCCT_IDLE: begin
        // calibration only advances while no conversion runs
        if (cal_active_reg && bc_tick) begin
          if (cal_cnt_reg == CAL_LAST) begin
            cal_active_next = 1'b0;
          end else begin
            cal_cnt_next = cal_cnt_reg + 12'h001;
          end
        end
        if (conv_start) begin
          state_next       = adcct_pkg::ADCCT_SAMPLE;
          cfg_next         = '{clk_div_sel: conv_clock_divider_sel,
                               smp_len_sel: sample_length_sel};
          div_cnt_next     = 4'h0;
          bc_cnt_next      = 6'h00;
        end
      end
      adcct_pkg::ADCCT_SAMPLE: begin
        hold_next = ain_sync_reg;
        if (bc_tick) begin
          if (bc_cnt_reg == smp_m1(cfg_reg.smp_len_sel)) begin
            state_next  = adcct_pkg::ADCCT_CONVERT;
            bc_cnt_next = 6'h00;
          end else begin
            bc_cnt_next = bc_cnt_reg + 6'h01;
          end
        end
      end
      adcct_pkg::ADCCT_CONVERT: begin
        // hold stays frozen here, so late input changes are ignored
        if (bc_tick) begin
          if (bc_cnt_reg == `ADCCT_CONV_BC_M1) begin
            state_next    = adcct_pkg::ADCCT_LOAD;
            load_cnt_next = 1'b0;
          end else begin
            bc_cnt_next = bc_cnt_reg + 6'h01;
          end
        end
      end
      adcct_pkg::ADCCT_LOAD: begin
        if (load_cnt_reg == `ADCCT_LOAD_CPU_M1) begin
          state_next     = adcct_pkg::ADCCT_IDLE;
          conv_done_next = 1'b1;
          div_cnt_next   = 4'h0;
          if (hold_reg.below) begin
            result_next = `ADCCT_RESULT_ZERO;
          end else if (hold_reg.above) begin
            result_next = `ADCCT_RESULT_FULL;
          end else begin
            result_next = hold_reg.code;
          end
        end else begin
          load_cnt_next = 1'b1;
        end
      end
      default: begin
        state_next = adcct_pkg::ADCCT_IDLE;
      end
    endcase
    busy_next         = (state_next != adcct_pkg::ADCCT_IDLE);
    sample_phase_next = (state_next == adcct_pkg::ADCCT_SAMPLE);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg        <= adcct_pkg::ADCCT_IDLE;
      cfg_reg          <= '0;
      hold_reg         <= '0;
      div_cnt_reg      <= 4'h0;
      bc_cnt_reg       <= 6'h00;
      load_cnt_reg     <= 1'b0;
      cal_cnt_reg      <= 12'h000;
      cal_active_reg   <= 1'b1;
      result_reg       <= 10'h000;
      conv_done_reg    <= 1'b0;
      busy_reg         <= 1'b0;
      sample_phase_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg        <= state_next;
      cfg_reg          <= cfg_next;
      hold_reg         <= hold_next;
      div_cnt_reg      <= div_cnt_next;
      bc_cnt_reg       <= bc_cnt_next;
      load_cnt_reg     <= load_cnt_next;
      cal_cnt_reg      <= cal_cnt_next;
      cal_active_reg   <= cal_active_next;
      result_reg       <= result_next;
      conv_done_reg    <= conv_done_next;
      busy_reg         <= busy_next;
      sample_phase_reg <= sample_phase_next;
    end
  end

endmodule : adcct_top

`default_nettype wire

// file: adcct_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module adcct_asserts #(
  parameter int CAL_BC_PERIODS = 3328
) (
  input wire logic                  clk,
  input wire logic                  reset_n,
  input wire logic                  clk_en,
  input wire logic [1:0]            conv_clock_divider_sel,
  input wire logic [1:0]            sample_length_sel,
  input wire logic                  conv_start,
  input wire adcct_pkg::adcct_ain_t ain_pin,
  input wire logic [9:0]            result_reg,
  input wire logic                  conv_done_reg,
  input wire logic                  busy_reg,
  input wire logic                  sample_phase_reg,
  input wire logic                  cal_active_reg
);
  logic [11:0] n_reg, m_reg;
  logic [3:0]  sel_reg;
  logic        acc;
  int          bc;
  int          exp_s;
  int          cal_cyc;
  assign acc = clk_en && conv_start && !busy_reg;
  // shift code maps select 00,01,10,11 to 4,2,16,8
  assign bc = 2 << {sel_reg[3], ~sel_reg[2]};
  assign exp_s = (8 << sel_reg[1:0]) * bc;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      n_reg   <= '0;
      m_reg   <= '0;
      sel_reg <= '0;
    end else if (acc) begin
      n_reg   <= 12'h000;
      m_reg   <= 12'h000;
      sel_reg <= {conv_clock_divider_sel, sample_length_sel};
    end else if (clk_en) begin
      n_reg   <= n_reg + 12'(busy_reg);
      m_reg   <= m_reg + 12'(sample_phase_reg);
    end
  end
  // idle cycles spent calibrating; each basic tick needs at least two
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cal_cyc <= 0;
    end else if (clk_en && cal_active_reg && !busy_reg) begin
      cal_cyc <= cal_cyc + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_done_pulse: assert property (conv_done_reg |=> !conv_done_reg)
    else $error("done pulse too long");
  a_done_idle: assert property (conv_done_reg |-> !busy_reg && !sample_phase_reg)
    else $error("done while busy");
  a_accept_sample: assert property (acc |=> busy_reg && sample_phase_reg)
    else $error("accept did not start sampling");
  a_sample_busy: assert property (sample_phase_reg |-> busy_reg)
    else $error("sampling while idle");
  a_sample_len: assert property ($fell(sample_phase_reg) |-> m_reg == exp_s)
    else $error("sample phase length wrong");
  a_conv_len: assert property (conv_done_reg |-> n_reg == (exp_s + 40 * bc + 2))
    else $error("conversion length wrong");
  a_result_hold: assert property ($changed(result_reg) |-> conv_done_reg)
    else $error("result moved without done");
  a_cal_pause: assert property ($fell(cal_active_reg) |-> !$past(busy_reg))
    else $error("calibration ended mid conversion");
  a_cal_len: assert property ($fell(cal_active_reg) |-> cal_cyc >= 2 * CAL_BC_PERIODS)
    else $error("calibration too short");
  a_cal_once: assert property (!cal_active_reg |=> !cal_active_reg)
    else $error("calibration restarted");
  c_done: cover property (conv_done_reg);
  c_cal_end: cover property ($fell(cal_active_reg));
  c_conv_in_cal: cover property (acc && cal_active_reg);
endmodule : adcct_asserts
bind adcct_top adcct_asserts #(.CAL_BC_PERIODS(CAL_BC_PERIODS)) u_chk (.clk, .reset_n,
  .clk_en, .conv_clock_divider_sel, .sample_length_sel, .conv_start, .ain_pin, .result_reg,
  .conv_done_reg, .busy_reg, .sample_phase_reg, .cal_active_reg);
`default_nettype wire

// file: adcct_ain_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcct_ain_model (
  input  wire logic signed [12:0] level,
  input  wire logic               clk,
  output var adcct_pkg::adcct_ain_t ain
);
  // code left raw when out of range, so clamping is really exercised
  always_ff @(posedge clk) begin
    ain.below <= level < 0;
    ain.above <= level > 13'sd1023;
    ain.code  <= level[9:0];
  end
endmodule : adcct_ain_model
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(w, e, s) begin checks++; if ((s) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", w, e, s); end end
module testbench;
  localparam int CAL = 20;
  logic                  clk, reset_n, clk_en, conv_start, done, smp, cal, busy;
  logic [1:0]            div_sel, smp_sel;
  logic [9:0]            result;
  logic signed [12:0]    level;
  adcct_pkg::adcct_ain_t ain;
  int                    n_errors = 0;
  int                    checks = 0;
  int                    t0, t1;
  adcct_ain_model u_src (.level(level), .clk(clk), .ain(ain));
  adcct_top #(.CAL_BC_PERIODS(CAL)) DUT (.clk, .reset_n, .clk_en, .conv_start,
    .conv_clock_divider_sel(div_sel), .sample_length_sel(smp_sel), .ain_pin(ain),
    .result_reg(result), .conv_done_reg(done), .busy_reg(busy), .sample_phase_reg(smp),
    .cal_active_reg(cal));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic final_report;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic cal_time(input bit with_conv, output int t);
    reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    conv_start <= with_conv;
    t = 0;
    do begin
      @(posedge clk);
      conv_start <= 1'b0;
      t++;
      #1;
    end while (cal === 1'b1 && t < 5000);
    if (t >= 5000) begin n_errors++; final_report; end
    @(posedge clk);
  endtask : cal_time
  task automatic conv(input logic [1:0] d, input logic [1:0] s, input int lv, input bit chg);
    int n, e, ns;
    bit late;
    e = lv < 0 ? 0 : lv > 1023 ? 1023 : lv;
    ns = 0;
    late = 1'b0;
    div_sel <= d;
    smp_sel <= s;
    level <= 13'(lv);
    repeat (3) @(posedge clk);
    conv_start <= 1'b1;
    @(posedge clk);
    conv_start <= 1'b0;
    #1;
    `CHK("busy after start", 1'b1, busy)
    if (smp === 1'b1) ns++;
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
      // late start and select change must be ignored mid conversion
      if (chg && n == 3) begin conv_start <= 1'b1; div_sel <= ~d; end
      if (chg && n == 4) conv_start <= 1'b0;
      // input moves only once the sample phase is seen to be over
      if (chg && late) level <= 13'sd2000;
      #1;
      if (smp === 1'b1) ns++;
      late = (smp === 1'b0);
    end
    if (n >= 2000) begin n_errors++; final_report; end
    `CHK("conv cycles", ((8 << s) + 40) * (2 << {d[1], ~d[0]}) + 2, n)
    `CHK("sample cycles", (8 << s) * (2 << {d[1], ~d[0]}), ns)
    `CHK("busy at done", 1'b0, busy)
    `CHK("result", 10'(e), result)
    @(posedge clk);
  endtask : conv
  task automatic test_cal;
    cal_time(1'b0, t0);
    `CHK("cal time", 1'b1, 1'(t0 >= CAL * 4 - 4 && t0 <= CAL * 4 + 4))
    cal_time(1'b1, t1);
    `CHK("cal ext", 1'b1, 1'(t1 - t0 >= 190 && t1 - t0 <= 198))
  endtask : test_cal
  task automatic test_sel;
    // levels walk from below ground to above reference across all selects
    // basic clock range is software's duty; cycle counts are frequency free
    for (int i = 0; i < 16; i++) conv(i[3:2], i[1:0], i * 90 - 200, 1'b0);
  endtask : test_sel
  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    conv_start = 1'b0;
    div_sel = 2'h0;
    smp_sel = 2'h0;
    level = '0;
    test_cal;
    test_sel;
    conv(2'h1, 2'h0, 300, 1'b1);
    final_report;
  end
endmodule : testbench
`default_nettype wire
